// File: rtl/dio_device.sv
// 24-channel open-drain bit i/o device with level-edge interrupt
`timescale 1ns/100ps
module dio_device
  import dio_pkg::*;
#(
  parameter logic [IO_ADDR_W-1:0] BASE_ADDR = BASE_DEFAULT
) (
  input wire logic clk_i,
  input wire logic rst_i,
  io_bus_if.dev bus,
  input wire logic [CHAN_N-1:0] pin_i,
  output logic [CHAN_N-1:0] pin_o,
  output logic [CHAN_N-1:0] pin_oe_n_o,
  input wire logic [SEL_W-1:0] irq_sel_i,
  input wire logic high_to_low_trigger_option_i
);

  // ---- input synchronisers ----
  // pins and option straps all come from outside the clock domain

  logic [SYNC_N-1:0] raw;
  logic [SYNC_N-1:0] s1_q;
  logic [SYNC_N-1:0] s2_q;
  logic [SYNC_N-1:0] s3_q;
  logic [SYNC_N-1:0] stable_q;

  assign raw = {high_to_low_trigger_option_i, irq_sel_i, pin_i};

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_N; gi++) begin : g_sync
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          s1_q[gi] <= 1'b1;
          s2_q[gi] <= 1'b1;
          s3_q[gi] <= 1'b1;
          stable_q[gi] <= 1'b1;
        end else begin
          s1_q[gi] <= raw[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
          // change accepted only when the two later stages agree
          if (s2_q[gi] == s3_q[gi]) begin
            stable_q[gi] <= s3_q[gi];
          end
        end
      end
    end
  endgenerate

  logic [CHAN_N-1:0] pin_lvl;
  logic [SEL_W-1:0] sel;
  logic high_to_low;

  assign pin_lvl = stable_q[CHAN_N-1:0];
  assign sel = stable_q[CHAN_N+SEL_W-1:CHAN_N];
  assign high_to_low = stable_q[SYNC_N-1];

  // ---- address decode ----

  logic hit;
  logic [1:0] ofs;
  logic wr_hit;
  logic rd_hit;

  assign hit = bus.addr[IO_ADDR_W-1:2] == BASE_ADDR[IO_ADDR_W-1:2];
  assign ofs = bus.addr[1:0];
  assign wr_hit = bus.wr & hit;
  assign rd_hit = bus.rd & hit;

  // ---- output latches ----
  // held inverted so the open-drain enable is itself the flip-flop;
  // there is no direction register, a cleared latch simply lets the
  // pull-up and any external driver decide the pin

  logic [CHAN_N-1:0] drive_n_q;
  logic [CHAN_N-1:0] pin_out_q;

  genvar gp;
  generate
    for (gp = 0; gp < PORT_N; gp++) begin : g_port
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          drive_n_q[gp*PORT_W +: PORT_W] <=
            DRIVE_N_RST[gp*PORT_W +: PORT_W];
        end else if (wr_hit && ofs == 2'(gp)) begin
          // a 1 bit enables the sink, a 0 bit releases the pin
          drive_n_q[gp*PORT_W +: PORT_W] <= ~bus.wdata;
        end
      end
    end
  endgenerate

  // the pin level is only ever pulled low, never driven high
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_out_q <= '0;
    end else begin
      pin_out_q <= '0;
    end
  end

  assign pin_oe_n_o = drive_n_q;
  assign pin_o = pin_out_q;

  // ---- level-edge interrupt detector ----

  logic src_valid;
  logic src_lvl;
  logic [CHAN_N-1:0] src_hot;
  logic active;
  logic [FILT_W-1:0] filt_q;
  logic fire;
  logic pend_q;
  logic stat_clr;

  // selections 24..31 mean no source channel
  assign src_valid = sel < SEL_W'(CHAN_N);
  // one compare per channel, so no index can run past the pin vector
  genvar gc;
  generate
    for (gc = 0; gc < CHAN_N; gc++) begin : g_src
      assign src_hot[gc] = pin_lvl[gc] && sel == SEL_W'(gc);
    end
  endgenerate

  assign src_lvl = |src_hot;

  // idle high means active low, and the other way round
  always_comb begin
    if (!src_valid) begin
      active = 1'b0;
    end else if (high_to_low) begin
      active = ~src_lvl;
    end else begin
      active = src_lvl;
    end
  end

  // short noise filter; a quarter of the shortest pulse keeps 2 us safe
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      filt_q <= '0;
    end else if (!active) begin
      filt_q <= '0;
    end else if (filt_q != FILT_W'(FILT_CYC - 1)) begin
      filt_q <= filt_q + FILT_W'(1);
    end
  end

  // stays high for as long as the source holds its active level
  assign fire = active && filt_q == FILT_W'(FILT_CYC - 1);

  assign stat_clr = wr_hit && ofs == OFS_STATUS;

  // set wins over clear, so a source still active keeps requesting
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_q <= 1'b0;
    end else if (fire) begin
      pend_q <= 1'b1;
    end else if (stat_clr) begin
      pend_q <= 1'b0;
    end
  end

  assign bus.irq = pend_q;

  // ---- read path ----
  // reads see the pin through the synchroniser, so a fresh write shows
  // up in the read-back about four cycles later

  logic [PORT_W-1:0] rdata_q;
  logic rvalid_q;
  logic [PORT_W-1:0] rd_mux;

  always_comb begin
    rd_mux = UNCLAIMED_RDATA;
    if (hit) begin
      unique case (ofs)
        OFS_PORT_LOW: rd_mux = ~pin_lvl[0 +: PORT_W];
        OFS_PORT_MID: rd_mux = ~pin_lvl[PORT_W +: PORT_W];
        OFS_PORT_HIGH: rd_mux = ~pin_lvl[2*PORT_W +: PORT_W];
        OFS_STATUS: begin
          rd_mux = 8'h00;
          rd_mux[PEND_BIT] = pend_q;
        end
      endcase
    end
  end

  // every read is answered; outside the window the bus floats high
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_q <= RDATA_RST;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= bus.rd;
      if (rd_hit) begin
        rdata_q <= rd_mux;
      end else if (bus.rd) begin
        rdata_q <= UNCLAIMED_RDATA;
      end
    end
  end

  assign bus.rdata = rdata_q;
  assign bus.rvalid = rvalid_q;

endmodule

// File: rtl/dio_pkg.sv
// constants and types shared by both ends of the 24-channel bit i/o link
package dio_pkg;

  localparam int IO_ADDR_W = 10;
  localparam int PORT_W = 8;
  localparam int PORT_N = 3;
  localparam int CHAN_N = 24;
  localparam int SEL_W = 5;
  localparam int SYNC_N = CHAN_N + SEL_W + 1;

  // byte offsets inside the four-byte window
  localparam logic [1:0] OFS_PORT_LOW = 2'h0;
  localparam logic [1:0] OFS_PORT_MID = 2'h1;
  localparam logic [1:0] OFS_PORT_HIGH = 2'h2;
  localparam logic [1:0] OFS_STATUS = 2'h3;
  localparam logic [IO_ADDR_W-1:0] BASE_DEFAULT = 10'h300;
  localparam int PEND_BIT = 0;

  // reset values
  localparam logic [CHAN_N-1:0] DRIVE_N_RST = 24'hFFFFFF;
  localparam logic [PORT_W-1:0] RDATA_RST = 8'h00;
  localparam logic [PORT_W-1:0] UNCLAIMED_RDATA = 8'hFF;

  // timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int PULSE_MIN_NS = 2000;
  localparam int PULSE_MIN_CYC = PULSE_MIN_NS / CLK_PERIOD_NS;
  localparam int FILT_CYC = PULSE_MIN_CYC / 4;
  localparam int FILT_W = 7;

  // host controller wishbone map
  localparam int WB_ADR_W = 8;
  localparam logic [WB_ADR_W-1:0] WB_OFS_ADDR = 8'h00;
  localparam logic [WB_ADR_W-1:0] WB_OFS_WDATA = 8'h04;
  localparam logic [WB_ADR_W-1:0] WB_OFS_CTRL = 8'h08;
  localparam logic [WB_ADR_W-1:0] WB_OFS_STATUS = 8'h0C;
  localparam logic [WB_ADR_W-1:0] WB_OFS_RDATA = 8'h10;
  localparam int CTRL_WR_BIT = 0;
  localparam int CTRL_RD_BIT = 1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_IRQ_BIT = 1;

  typedef enum logic [1:0] {
    H_IDLE = 2'b01,
    H_WAIT = 2'b10
  } host_state_t;

endpackage

// File: rtl/io_bus_if.sv
// 8-bit i/o bus between host controller and bit i/o device
`timescale 1ns/100ps
interface io_bus_if;
  import dio_pkg::*;
  logic [IO_ADDR_W-1:0] addr;
  logic [PORT_W-1:0] wdata;
  logic wr;
  logic rd;
  logic [PORT_W-1:0] rdata;
  logic rvalid;
  logic irq;

  modport dev (
    input addr,
    input wdata,
    input wr,
    input rd,
    output rdata,
    output rvalid,
    output irq
  );

  modport host (
    output addr,
    output wdata,
    output wr,
    output rd,
    input rdata,
    input rvalid,
    input irq
  );
endinterface

// File: rtl/dio_host.sv
// host controller: wishbone registers driving i/o bus cycles
`timescale 1ns/100ps
module dio_host
  import dio_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [WB_ADR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  io_bus_if.host bus
);

  logic ack_q;
  logic [31:0] dat_q;
  logic [IO_ADDR_W-1:0] addr_q;
  logic [PORT_W-1:0] wdata_q;
  logic [PORT_W-1:0] rdata_q;
  logic wr_q;
  logic rd_q;
  host_state_t state_q;
  logic req;
  logic wr_acc;
  logic go_wr;
  logic go_rd;
  logic busy;

  assign req = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr_acc = req & wb_we_i & wb_sel_i[0];
  assign busy = (state_q != H_IDLE) | wr_q;
  // a start while busy is dropped; write wins if both bits are set
  assign go_wr = wr_acc & (wb_adr_i == WB_OFS_CTRL) & ~busy
                 & wb_dat_i[CTRL_WR_BIT];
  assign go_rd = wr_acc & (wb_adr_i == WB_OFS_CTRL) & ~busy
                 & ~wb_dat_i[CTRL_WR_BIT] & wb_dat_i[CTRL_RD_BIT];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_q <= 32'h0;
    end else if (req & ~wb_we_i) begin
      unique case (wb_adr_i)
        WB_OFS_ADDR: dat_q <= {22'h0, addr_q};
        WB_OFS_WDATA: dat_q <= {24'h0, wdata_q};
        WB_OFS_STATUS: dat_q <= {30'h0, bus.irq, busy};
        WB_OFS_RDATA: dat_q <= {24'h0, rdata_q};
        default: dat_q <= 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      addr_q <= BASE_DEFAULT;
      wdata_q <= 8'h00;
    end else if (wr_acc & ~busy) begin
      if (wb_adr_i == WB_OFS_ADDR) begin
        addr_q <= wb_dat_i[IO_ADDR_W-1:0];
      end
      if (wb_adr_i == WB_OFS_WDATA) begin
        wdata_q <= wb_dat_i[PORT_W-1:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      state_q <= H_IDLE;
      rdata_q <= RDATA_RST;
    end else begin
      wr_q <= go_wr;
      rd_q <= go_rd;
      unique case (state_q)
        H_IDLE: begin
          if (go_rd) begin
            state_q <= H_WAIT;
          end
        end
        H_WAIT: begin
          if (bus.rvalid) begin
            rdata_q <= bus.rdata;
            state_q <= H_IDLE;
          end
        end
      endcase
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign bus.addr = addr_q;
  assign bus.wdata = wdata_q;
  assign bus.wr = wr_q;
  assign bus.rd = rd_q;

endmodule

// File: sim/dio_sva.sv
// assertions on the i/o bus between host controller and device
`timescale 1ns/100ps
module dio_sva
  import dio_pkg::*;
#(
  parameter logic [IO_ADDR_W-1:0] BASE_ADDR = BASE_DEFAULT
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [IO_ADDR_W-1:0] addr,
  input wire logic [PORT_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [PORT_W-1:0] rdata,
  input wire logic rvalid,
  input wire logic irq
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic hit;
  logic st;
  assign hit = addr[9:2] == BASE_ADDR[9:2];
  assign st = hit && addr[1:0] == OFS_STATUS;
  a_read_answered: assert property (rd |=> rvalid ##1 !rvalid)
    else $error("read not answered in one cycle");
  a_answer_needs_read: assert property (rvalid |-> $past(rd))
    else $error("answer without read");
  a_miss_reads_ff: assert property (rd && !hit |=> rdata == 8'hFF)
    else $error("outside read not 0xFF");
  a_status_flag: assert property (
    rd && st |=> rdata == {7'h00, $past(irq)})
    else $error("status read wrong");
  a_flag_held: assert property (irq && !(wr && st) |=> irq)
    else $error("pending lost without clear");
  a_reset_clears: assert property (
    disable iff (1'b0) rst_i |=> !irq)
    else $error("reset left pending set");
  a_data_held: assert property (!rvalid |-> $stable(rdata))
    else $error("read data moved");
  a_write_silent: assert property (wr && !rd |=> !rvalid)
    else $error("write answered");
  cover property (rd && st ##1 rdata[0]);
  cover property (wr && st && irq);
  cover property ($rose(irq));
endmodule

// File: sim/bit_io_with_edge_interrupt_test.sv
// self-checking bench joining host controller and device
`timescale 1ns/100ps
module bit_io_with_edge_interrupt_test;
  import dio_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [WB_ADR_W-1:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] wq;
  logic ack;
  logic [CHAN_N-1:0] ext_n = 24'hFFFFFF;
  logic [CHAN_N-1:0] pin_o;
  logic [CHAN_N-1:0] oe_n;
  logic [CHAN_N-1:0] pin;
  logic [SEL_W-1:0] sel = 5'h18;
  logic h2l = 1'b1;
  logic [IO_ADDR_W-1:0] sa;
  int n_mismatch = 0;
  int checked = 0;
  io_bus_if bus ();
  always #2 clk_i = ~clk_i;
  // open drain: pulled up unless the device or the field sinks it
  assign pin = ext_n & (oe_n | pin_o);
  assign sa = BASE_DEFAULT + 10'h3;
  dio_host i_dio_host (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_sel_i(4'hF), .wb_dat_o(rdat), .wb_ack_o(ack), .bus(bus));
  dio_device #(.BASE_ADDR(BASE_DEFAULT)) i_dio_device (.clk_i(clk_i),
    .rst_i(rst_i), .bus(bus), .pin_i(pin), .pin_o(pin_o),
    .pin_oe_n_o(oe_n), .irq_sel_i(sel), .high_to_low_trigger_option_i(h2l));
  dio_sva #(.BASE_ADDR(BASE_DEFAULT)) i_dio_sva (.clk_i(clk_i),
    .rst_i(rst_i), .addr(bus.addr), .wdata(bus.wdata), .wr(bus.wr),
    .rd(bus.rd), .rdata(bus.rdata), .rvalid(bus.rvalid), .irq(bus.irq));
  task wrap_up;
    if (n_mismatch == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    for (k = 0; k < 20; k++) begin
      @(posedge clk_i);
      if (ack === 1'b1) break;
    end
    if (k == 20) begin
      n_mismatch++;
      wrap_up();
    end
    wq = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // one i/o bus cycle through the host; read byte lands in wq
  task io(input logic w, input logic [9:0] a, input logic [7:0] d);
    int k;
    wb(1'b1, WB_OFS_ADDR, {22'h0, a});
    wb(1'b1, WB_OFS_WDATA, {24'h0, d});
    wb(1'b1, WB_OFS_CTRL, w ? 32'h1 : 32'h2);
    for (k = 0; k < 20; k++) begin
      wb(1'b0, WB_OFS_STATUS, 32'h0);
      if (wq[STAT_BUSY_BIT] === 1'b0) break;
    end
    if (k == 20) begin
      n_mismatch++;
      wrap_up();
    end
    if (!w) wb(1'b0, WB_OFS_RDATA, 32'h0);
  endtask
  task t_reset;
    int p;
    check(oe_n, 24'hFFFFFF);
    for (p = 0; p < 4; p++) begin
      io(1'b0, BASE_DEFAULT + 10'(p), 8'h00);
      check(wq[7:0], 8'h00);
    end
  endtask
  task t_out;
    int p;
    for (p = 0; p < 3; p++) begin
      io(1'b1, BASE_DEFAULT + 10'(p), 8'hA5 + 8'(p));
      check(oe_n[p*8 +: 8], 8'(~(8'hA5 + 8'(p))));
      check(pin[p*8 +: 8], 8'(~(8'hA5 + 8'(p))));
      io(1'b0, BASE_DEFAULT + 10'(p), 8'h00);
      check(wq[7:0], 8'hA5 + 8'(p));
      io(1'b1, BASE_DEFAULT + 10'(p), 8'h00);
    end
    check(oe_n, 24'hFFFFFF);
    io(1'b1, 10'h304, 8'hFF);
    check(oe_n, 24'hFFFFFF);
    io(1'b0, 10'h2FF, 8'h00);
    check(wq[7:0], 8'hFF);
    wb(1'b0, 8'h20, 32'h0);
    check(wq, 32'h0);
  endtask
  task t_in;
    int p;
    @(posedge clk_i);
    ext_n <= ~24'h003C81;
    repeat (10) @(posedge clk_i);
    for (p = 0; p < 3; p++) begin
      io(1'b0, BASE_DEFAULT + 10'(p), 8'h00);
      check(wq[7:0], 8'(24'h003C81 >> (p * 8)));
    end
    ext_n <= 24'hFFFFFF;
  endtask
  task t_irq(input int ch, input logic opt);
    logic [CHAN_N-1:0] idle_n;
    idle_n = opt ? 24'hFFFFFF : ~(24'h1 << ch);
    @(posedge clk_i);
    sel <= 5'(ch);
    h2l <= opt;
    ext_n <= idle_n;
    repeat (300) @(posedge clk_i);
    io(1'b1, sa, 8'h00);
    io(1'b0, sa, 8'h00);
    check(wq[7:0], 8'h00);
    ext_n <= idle_n ^ (24'h1 << ch);
    repeat (500) @(posedge clk_i);
    ext_n <= idle_n;
    repeat (300) @(posedge clk_i);
    io(1'b0, sa, 8'h00);
    check(wq[7:0], 8'h01);
    wb(1'b0, WB_OFS_STATUS, 32'h0);
    check(wq[STAT_IRQ_BIT], 1'b1);
    io(1'b1, sa, 8'h5A);
    io(1'b0, sa, 8'h00);
    check(wq[7:0], 8'h00);
    ext_n <= idle_n ^ (24'h1 << ch);
    repeat (300) @(posedge clk_i);
    io(1'b1, sa, 8'hFF);
    io(1'b0, sa, 8'h00);
    check(wq[7:0], 8'h01);
    ext_n <= idle_n;
    repeat (300) @(posedge clk_i);
    io(1'b1, sa, 8'h00);
    io(1'b0, sa, 8'h00);
    check(wq[7:0], 8'h00);
  endtask
  task t_none;
    int i;
    for (i = 0; i < 2; i++) begin
      @(posedge clk_i);
      sel <= i ? 5'h05 : 5'h18;
      h2l <= 1'b1;
      ext_n <= i ? ~24'h40 : ~24'h1;
      repeat (500) @(posedge clk_i);
      ext_n <= 24'hFFFFFF;
      repeat (20) @(posedge clk_i);
      io(1'b0, sa, 8'h00);
      check(wq[7:0], 8'h00);
    end
  endtask
  // the channel's own sink is the source, then a reset mid-run
  task t_rst;
    @(posedge clk_i);
    sel <= 5'h00;
    io(1'b1, BASE_DEFAULT, 8'h01);
    repeat (300) @(posedge clk_i);
    io(1'b0, sa, 8'h00);
    check(wq[7:0], 8'h01);
    rst_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    check(oe_n, 24'hFFFFFF);
    io(1'b0, sa, 8'h00);
    check(wq[7:0], 8'h00);
  endtask
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_out();
    t_in();
    t_irq(0, 1'b1);
    t_irq(23, 1'b0);
    t_none();
    t_rst();
    wrap_up();
  end
endmodule
